// ### hw/blc_pkg.sv
package blc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 7;
  localparam logic [7:0] DAYLIGHT_DIM_OFFSET = 8'h0a;
  localparam logic [7:0] OFFICE_MAX_OFFSET = 8'h0b;
  localparam int CODE_LSB = 0;
  localparam int RSVD_BIT = 7;
  localparam logic [6:0] DAYLIGHT_DIM_RESET = 7'h00;
  localparam logic [6:0] OFFICE_MAX_RESET = 7'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [1:0] LAW_LINEAR = 2'h0;
  localparam logic [1:0] LAW_SQUARE = 2'h1;
  localparam logic [1:0] LAW_CUBIC10 = 2'h2;
  localparam logic [1:0] LAW_CUBIC11 = 2'h3;

  typedef enum logic [1:0] {
    BLC_BRIGHT = 2'b01,
    BLC_DIMMED = 2'b10
  } blc_dim_type;
endpackage : blc_pkg

// ### hw/blc_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - A dim timeout switches the daylight target from its maximum code to the stored dim code.
// - The daylight dim register at 0x0A holds a 7-bit code in bits 6 to 0, bit 7 reserved.
// - The office maximum register at 0x0B holds a 7-bit code in its low bits, bit 7 reserved.
// - Both cubic laws use the square code-to-current map and vary the time per code step.
// - Setting the dim-enable flag applies the dim code at once, just as a dim timeout would.
module blc_regs (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [blc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [blc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [blc_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic [blc_pkg::CODE_W-1:0] DAYLIGHT_MAX_CODE,
  input wire logic DIM_TIMEOUT,
  input wire logic DIM_EN,
  input wire logic WAKE,
  input wire logic [1:0] FADE_LAW,
  output logic [blc_pkg::CODE_W-1:0] DAYLIGHT_TARGET_CODE,
  output logic [blc_pkg::CODE_W-1:0] OFFICE_MAX_CODE,
  output logic DIM_ACTIVE,
  output logic SQUARE_MAP,
  output logic STEP_VARY
);
  import blc_pkg::*;

  typedef struct packed {
    logic [CODE_W-1:0] daylight_dim_code;
    logic [CODE_W-1:0] office_max_code;
    blc_dim_type dim;
    logic dim_active;
    logic [CODE_W-1:0] target;
    logic [DATA_W-1:0] rdata;
    logic square_map;
    logic step_vary;
  } blc_state_type;

  blc_state_type state_r;
  blc_state_type state_nxt;

  // The decodes are shared by the next-state logic and by the checks at the bottom.
  wire logic wr_dim = REG_WE && (REG_ADDR == DAYLIGHT_DIM_OFFSET);
  wire logic wr_max = REG_WE && (REG_ADDR == OFFICE_MAX_OFFSET);
  wire logic rd_dim = REG_RE && (REG_ADDR == DAYLIGHT_DIM_OFFSET);
  wire logic rd_max = REG_RE && (REG_ADDR == OFFICE_MAX_OFFSET);
  wire logic wake_ok = WAKE && !DIM_EN && !DIM_TIMEOUT;
  wire logic [CODE_W-1:0] wdata_code = REG_WDATA[CODE_LSB +: CODE_W];

  always_comb begin
    state_nxt = state_r;
    // Only the low seven bits are stored, so bit 7 of a write is lost.
    if (wr_dim) begin
      state_nxt.daylight_dim_code = REG_WDATA[CODE_LSB +: CODE_W];
    end
    if (wr_max) begin
      state_nxt.office_max_code = REG_WDATA[CODE_LSB +: CODE_W];
    end
    // A dim request in the same cycle as a wake wins, so no dim event is lost.
    case (state_r.dim)
      BLC_BRIGHT: begin
        if (DIM_TIMEOUT || DIM_EN) begin
          state_nxt.dim = BLC_DIMMED;
        end
      end
      BLC_DIMMED: begin
        if (wake_ok) begin
          state_nxt.dim = BLC_BRIGHT;
        end
      end
      default: begin
        state_nxt.dim = BLC_BRIGHT;
      end
    endcase
    if (state_nxt.dim == BLC_DIMMED) begin
      state_nxt.target = state_nxt.daylight_dim_code;
    end else begin
      state_nxt.target = DAYLIGHT_MAX_CODE;
    end
    state_nxt.dim_active = (state_nxt.dim == BLC_DIMMED);
    state_nxt.rdata = RDATA_RESET;
    if (rd_dim) begin
      state_nxt.rdata = {1'h0, state_r.daylight_dim_code};
    end else if (rd_max) begin
      state_nxt.rdata = {1'h0, state_r.office_max_code};
    end
    // Cubic shapes come from step timing on top of the square table.
    state_nxt.square_map = (FADE_LAW != LAW_LINEAR);
    state_nxt.step_vary = (FADE_LAW == LAW_CUBIC10) || (FADE_LAW == LAW_CUBIC11);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r.daylight_dim_code <= DAYLIGHT_DIM_RESET;
      state_r.office_max_code <= OFFICE_MAX_RESET;
      state_r.dim <= BLC_BRIGHT;
      state_r.dim_active <= 1'h0;
      state_r.target <= DAYLIGHT_DIM_RESET;
      state_r.rdata <= RDATA_RESET;
      state_r.square_map <= 1'b0;
      state_r.step_vary <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign REG_RDATA = state_r.rdata;
  assign DAYLIGHT_TARGET_CODE = state_r.target;
  assign OFFICE_MAX_CODE = state_r.office_max_code;
  assign DIM_ACTIVE = state_r.dim_active;
  assign SQUARE_MAP = state_r.square_map;
  assign STEP_VARY = state_r.step_vary;

  // The reset check has no disable, so that it sees the reset edges themselves.
  a_reset_clear: assert property (@(posedge CLK)
    RESET
    |=> (REG_RDATA == RDATA_RESET) && !DIM_ACTIVE && (OFFICE_MAX_CODE == OFFICE_MAX_RESET)
      && (DAYLIGHT_TARGET_CODE == DAYLIGHT_DIM_RESET) && !SQUARE_MAP && !STEP_VARY)
    else $error("Outputs are not at their reset values.");

  // A quiet cycle between write and read keeps a second write from hiding a lost one.
  a_dim_write_back: assert property (@(posedge CLK) disable iff (RESET)
    wr_dim ##1 !wr_dim ##1 rd_dim
    |=> REG_RDATA == {1'h0, $past(wdata_code, 3)})
    else $error("Dim code readback differs from the written code.");

  a_dim_hold: assert property (@(posedge CLK) disable iff (RESET)
    !wr_dim
    |=> $stable(state_r.daylight_dim_code))
    else $error("Dim code changed without a write.");

  a_max_store: assert property (@(posedge CLK) disable iff (RESET)
    wr_max
    |=> OFFICE_MAX_CODE == $past(wdata_code))
    else $error("Office maximum code not stored.");

  a_max_hold: assert property (@(posedge CLK) disable iff (RESET)
    !wr_max
    |=> $stable(OFFICE_MAX_CODE))
    else $error("Office maximum code changed without a write.");

  a_max_write_back: assert property (@(posedge CLK) disable iff (RESET)
    wr_max ##1 !wr_max ##1 rd_max
    |=> REG_RDATA == {1'h0, $past(wdata_code, 3)})
    else $error("Office maximum readback differs from the written code.");

  // Bit 7 is never stored, so a reread can only ever show zero there.
  a_rsvd_zero: assert property (@(posedge CLK) disable iff (RESET)
    $past(REG_RE)
    |-> REG_RDATA[RSVD_BIT] == 1'h0)
    else $error("Reserved bit read back as one.");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (RESET)
    !REG_RE
    |=> REG_RDATA == RDATA_RESET)
    else $error("Read data is not zero outside a read.");

  a_unmapped_zero: assert property (@(posedge CLK) disable iff (RESET)
    REG_RE && !rd_dim && !rd_max
    |=> REG_RDATA == RDATA_RESET)
    else $error("Unmapped read returned a nonzero value.");

  // The target follows the stored dim code, which a write may change while dimmed.
  a_timeout_dims: assert property (@(posedge CLK) disable iff (RESET)
    DIM_TIMEOUT
    |=> DIM_ACTIVE && (DAYLIGHT_TARGET_CODE == state_r.daylight_dim_code))
    else $error("Dim timeout did not select the dim code.");

  a_dim_code_follow: assert property (@(posedge CLK) disable iff (RESET)
    DIM_ACTIVE && wr_dim && !wake_ok
    |=> DAYLIGHT_TARGET_CODE == $past(wdata_code))
    else $error("Dim target did not follow a new dim code.");

  a_dim_sticky: assert property (@(posedge CLK) disable iff (RESET)
    DIM_ACTIVE && !WAKE
    |=> DIM_ACTIVE)
    else $error("Dim state left without a wake.");

  a_bright_max: assert property (@(posedge CLK) disable iff (RESET)
    !DIM_ACTIVE && !$past(RESET)
    |-> DAYLIGHT_TARGET_CODE == $past(DAYLIGHT_MAX_CODE))
    else $error("Bright target is not the maximum code.");

  a_wake_clears: assert property (@(posedge CLK) disable iff (RESET)
    wake_ok
    |=> !DIM_ACTIVE)
    else $error("A wake did not leave the dim state.");

  // The enable flag is a level, so it must also keep a wake from undoing the dim.
  a_dim_en_hold: assert property (@(posedge CLK) disable iff (RESET)
    DIM_EN [*2]
    |-> DIM_ACTIVE && (DAYLIGHT_TARGET_CODE == state_r.daylight_dim_code))
    else $error("Dim enable did not apply the dim code.");

  a_dim_en_now: assert property (@(posedge CLK) disable iff (RESET)
    DIM_EN
    |=> DIM_ACTIVE && (DAYLIGHT_TARGET_CODE == state_r.daylight_dim_code))
    else $error("Dim enable was not applied at once.");

  a_wake_refused: assert property (@(posedge CLK) disable iff (RESET)
    WAKE && (DIM_EN || DIM_TIMEOUT)
    |=> DIM_ACTIVE)
    else $error("A wake overrode a dim request.");

  // Law decode feeds the fade engine, which only sees the two flags.
  a_cubic_square: assert property (@(posedge CLK) disable iff (RESET)
    FADE_LAW[1]
    |=> SQUARE_MAP && STEP_VARY)
    else $error("Cubic law must use the square map with varied steps.");

  a_square_only: assert property (@(posedge CLK) disable iff (RESET)
    FADE_LAW == LAW_SQUARE
    |=> SQUARE_MAP && !STEP_VARY)
    else $error("Square law must use the square map with fixed steps.");

  a_linear_map: assert property (@(posedge CLK) disable iff (RESET)
    FADE_LAW == LAW_LINEAR
    |=> !SQUARE_MAP && !STEP_VARY)
    else $error("Linear law must not use the square map.");
endmodule : blc_regs

// ### tb/blc_host.sv
`timescale 1ns/10ps
module blc_host (
  input wire logic CLK,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic we,
  output logic re
);
  initial begin
    {addr, wdata, we, re} = 18'h00000;
  end
  // A released bus shows the inverse address and data with both strobes low, so stale values never pass as fresh ones.
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge CLK);
    {addr, wdata, we, re} = {a, d, w, ~w};
    @(negedge CLK);
    {addr, wdata, we, re} = {~a, ~d, 2'h0};
  endtask : acc
endmodule : blc_host

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, reset = 1'b1, tmo = 1'b0, den = 1'b0, wake = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic we, re, act, sq, sv;
  logic [6:0] max = 7'h00, tgt, off;
  logic [1:0] law = 2'h0;
  int num_errors = 0, n_tests = 0, cyc = 0, dimd = 0, m[2] = '{0, 0};
  initial forever #5 clk = ~clk;
  blc_host u_blc_host (.CLK(clk), .addr(addr), .wdata(wdata), .we(we), .re(re));
  blc_regs u_blc_regs (.CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .DAYLIGHT_MAX_CODE(max), .DIM_TIMEOUT(tmo),
    .DIM_EN(den), .WAKE(wake), .FADE_LAW(law), .DAYLIGHT_TARGET_CODE(tgt),
    .OFFICE_MAX_CODE(off), .DIM_ACTIVE(act), .SQUARE_MAP(sq), .STEP_VARY(sv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_blc_host.acc(a, d, 1'b1);
    if (a inside {8'h0a, 8'h0b}) m[a - 8'h0a] = d & 8'h7f;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int e);
    u_blc_host.acc(a, 8'($urandom), 1'b0);
    chk(rdata, 8'(e));
  endtask : rd
  // Timeout and wake are held one cycle and the enable stays until the next call, then the outputs are checked against the model.
  task automatic dim(input logic t, input logic e, input logic w);
    @(negedge clk);
    {tmo, den, wake} = {t, e, w};
    dimd = (t || e) ? 1 : (w ? 0 : dimd);
    @(negedge clk);
    {tmo, wake} = 2'h0;
    chk({7'h00, act}, 8'(dimd));
    chk({1'b0, tgt}, 8'(dimd ? m[0] : max));
  endtask : dim
  always @(posedge clk) if (++cyc == 3000) begin
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(34));
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd(8'h0a, 0);
    rd(8'h0b, 0);
    repeat (4) for (int i = 0; i < 2; i++) begin
      wr(8'h0a + 8'(i), 8'($urandom) | 8'h80);
      rd(8'h0a + 8'(i), m[i]);
      chk({1'b0, off}, 8'(m[1]));
    end
    wr(8'h0c, 8'($urandom));
    rd(8'h0c, 0);
    max = 7'($urandom);
    dim(1'b1, 1'b0, 1'b0);
    dim(1'b0, 1'b0, 1'b1);
    dim(1'b0, 1'b1, 1'b1);
    wr(8'h0a, 8'($urandom));
    chk({1'h0, tgt}, 8'(m[0]));
    dim(1'b0, 1'b0, 1'b1);
    for (int l = 0; l < 4; l++) begin
      @(negedge clk) law = 2'(l);
      @(negedge clk) chk({6'h00, sq, sv}, 8'((l != 0) * 2 + (l >= 2)));
    end
    dim(1'h1, 1'h0, 1'h0);
    @(negedge clk) reset = 1'h1;
    repeat (2) @(negedge clk);
    chk({act, tgt}, 8'h00);
    reset = 1'h0;
    m = '{0, 0};
    dimd = 0;
    rd(8'h0a, 0);
    rd(8'h0b, 0);
    dim(1'h0, 1'h0, 1'h0);
    summarize();
  end
endmodule : tb_top
